// *** common/cfs_pkg.sv ***
`default_nettype none
package cfs_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 32'h32; // 50 ns clock period
  localparam int MS_NS = 32'h000f4240; // 1 ms
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam logic [7:0] TRK_MIN_MS = 8'h05; // 5 ms floor on tracked ramps

  // ----------------------------------------------------------------
  // thresholds, millivolts and degrees
  // ----------------------------------------------------------------
  localparam logic [15:0] LOCK_LO = 16'h1194; // 4.5 V
  localparam logic [15:0] LOCK_HI = 16'h2a30; // 10.8 V
  localparam logic [15:0] LOCK_MIN = 16'h0b22; // 2.85 V
  localparam logic [15:0] LOCK_MAX = 16'h3e80; // 16 V
  localparam logic [7:0] TLIM_RST = 8'h7d; // 125 C
  localparam logic [7:0] T_HYST = 8'h0f; // 15 C
  localparam logic [7:0] OV_PCT_RST = 8'h0f; // 15 %
  localparam logic [6:0] PCT_RST = 7'h32; // 50 %
  localparam logic [31:0] PCT_FULL = 32'h64; // 100 %
  localparam logic [15:0] TGT_RST = 16'h04b0;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_LOCK = 5'h04;
  localparam logic [4:0] A_TGT = 5'h08;
  localparam logic [4:0] A_TIME = 5'h0c;
  localparam logic [4:0] A_RESP = 5'h10;
  localparam logic [4:0] A_TEMP = 5'h14;
  localparam logic [4:0] A_STAT = 5'h18;
  localparam int CTRL_EN = 0;
  localparam int CTRL_RESTART = 1;

  typedef enum logic [2:0] {
    S_OFF = 3'b000, S_DELAY = 3'b001, S_RAMP = 3'b010, S_RUN = 3'b011,
    S_WAIT = 3'b100, S_LOWHOLD = 3'b101, S_LATCH = 3'b110
  } fsm_t;
  typedef enum logic [2:0] {
    R_CONT = 3'b000, R_DLY = 3'b001, R_IMM = 3'b010, R_INF = 3'b011,
    R_LOW = 3'b100
  } resp_t;
  typedef enum logic [2:0] {
    T_OFF = 3'b000, T_CO_OUT = 3'b001, T_CO_REF = 3'b010,
    T_RA_OUT = 3'b011, T_RA_REF = 3'b100
  } trk_t;
  typedef enum logic [1:0] {
    F_UV = 2'b00, F_OV = 2'b01, F_OC = 2'b10, F_OT = 2'b11
  } fault_t;

  typedef struct packed {
    logic [7:0] flt_dly;
    logic [7:0] rty_dly;
    logic [7:0] rise;
    logic [7:0] on_dly;
  } timing_t;
  typedef struct packed {
    logic [7:0] ov_pct;
    logic [4:0] rsv;
    trk_t trk;
    logic [3:0] rty_max;
    resp_t ot;
    resp_t oc;
    resp_t ov;
    resp_t uv;
  } resp_reg_t;
  localparam timing_t TIME_RST = 32'h0a0a0505;
  localparam resp_reg_t RESP_RST = 32'h0f000492;

  typedef struct packed {
    fsm_t st;
    logic en;
    logic [15:0] lock;
    logic [15:0] tgt;
    timing_t tm;
    resp_reg_t rp;
    logic [7:0] tlim;
    logic [6:0] pct;
    logic sdone;
    logic [15:0] tcnt;
    logic [7:0] ms;
    logic [7:0] dcnt;
    logic [15:0] sv;
    logic above;
    logic [3:0] att;
    fault_t flt;
    logic good;
    logic hs;
    logic ls;
    logic [15:0] ref_mv;
    logic wr;
    logic [4:0] wa;
    logic [31:0] rdata;
    logic rdy;
  } state_t;
  localparam state_t ST_RST = '{tm: TIME_RST, rp: RESP_RST, tgt: TGT_RST,
    tlim: TLIM_RST, lock: LOCK_LO, pct: PCT_RST, rdy: 1'b1, st: S_OFF,
    flt: F_UV, default: '0};
endpackage : cfs_pkg
`default_nettype wire

// *** verilog/converter_fault_supervisor.sv ***
`default_nettype none
// Overview of operation
// (R1) lockout threshold taken from strap after reset: 4.5 V or 10.8 V
// (R2) software lockout threshold accepted and clamped to 2.85 V..16 V
// (R3) undervoltage response: continue, delayed shutdown, or shutdown/retry
// (R4) undervoltage defaults to immediate shutdown
// (R5) overvoltage above target plus 15 % drops power good first
// (R6) overvoltage: shutdown with retries, or low-side held on
// (R7) overvoltage defaults to shutdown; external clock forces shutdown
// (R8) pre-bias below target: ramp from sampled level, end on time
// (R9) pre-bias above target: hold sampled level, then move to target
// (R10) power good at ramp end unless above overvoltage limit
// (R11) pre-bias above overvoltage limit: no start, overvoltage fault
// (R12) overcurrent: infinite, limited retry, delayed, ignore, immediate
// (R13) overcurrent defaults to immediate shutdown
// (R14) die temperature above programmable limit raises thermal fault
// (R15) thermal fault offers same five responses as overcurrent
// (R16) thermal restart only once 15 C below the limit
// (R17) thermal fault defaults to immediate shutdown
// (R18) coincident, output limited: follow reference, stop at target
// (R19) coincident, reference limited: follow reference throughout
// (R20) ratiometric: follow percentage of reference, strap default 50 %
// (R21) ratiometric output limited: stop at percentage of target
// (R22) ratiometric reference limited: stop at scaled rail or target
// (R23) tracked ramps use at least 5 ms rise time
// (R24) retry counter cleared after a successful restart
module converter_fault_supervisor #(
  parameter int MS_CYCLES = cfs_pkg::MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] output_sense_in,
  input wire logic [15:0] tracking_reference_in,
  input wire logic [7:0] die_temp,
  input wire logic overcurrent_in,
  input wire logic ext_clock_in,
  input wire logic strap_high_lockout,
  input wire logic [6:0] ratio_strap,
  output logic power_good_out,
  output logic high_side_en,
  output logic low_side_en,
  output logic [15:0] ref_mv
);
  cfs_pkg::state_t s;
  cfs_pkg::state_t n;
  logic [16:0] ov_lim;
  logic uv_now, ov_now, ot_now, cool, tick, trk_on;
  logic [7:0] rise_eff;
  logic [15:0] scaled, trk_lim, trk_ref, ramp_ref, wlock;
  cfs_pkg::resp_t ovr, uvr;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd(input cfs_pkg::state_t q,
                                     input logic [4:0] a, input logic [3:0] fl);
    if (a == cfs_pkg::A_CTRL)
      rd = {31'h0, q.en};
    else if (a == cfs_pkg::A_LOCK)
      rd = {16'h0, q.lock};
    else if (a == cfs_pkg::A_TGT)
      rd = {16'h0, q.tgt};
    else if (a == cfs_pkg::A_TIME)
      rd = q.tm;
    else if (a == cfs_pkg::A_RESP)
      rd = q.rp;
    else if (a == cfs_pkg::A_TEMP)
      rd = {24'h0, q.tlim};
    else if (a == cfs_pkg::A_STAT)
      rd = {16'h0, q.good, q.hs, q.ls, q.st, q.flt, q.att, fl};
    else
      rd = 32'h0;
  endfunction : rd

  // ----------------------------------------------------------------
  // fault detectors and setpoint arithmetic
  // ----------------------------------------------------------------
  // limit kept one bit wider so a high target cannot wrap below it
  assign ov_lim = {1'b0, s.tgt} + 17'((32'(s.tgt) * 32'(s.rp.ov_pct))
                  / cfs_pkg::PCT_FULL); // R5
  assign uv_now = vin_mv < s.lock;
  assign ov_now = {1'b0, output_sense_in} > ov_lim; // R5
  assign ot_now = die_temp > s.tlim; // R14
  assign cool = 9'(die_temp) + 9'(cfs_pkg::T_HYST) <= 9'(s.tlim); // R16
  assign tick = s.tcnt == 16'(MS_CYCLES - 1);
  // an external clock leaves only the shutdown response for overvoltage
  assign ovr = (ext_clock_in || s.rp.ov != cfs_pkg::R_LOW) ?
               cfs_pkg::R_IMM : cfs_pkg::R_LOW; // R6 R7
  assign uvr = (s.rp.uv > cfs_pkg::R_IMM) ? cfs_pkg::R_IMM : s.rp.uv; // R3
  assign trk_on = s.rp.trk != cfs_pkg::T_OFF;
  // tracked ramps set loop gain from rise time, so a floor applies
  assign rise_eff = (trk_on && s.tm.rise < cfs_pkg::TRK_MIN_MS) ?
                    cfs_pkg::TRK_MIN_MS : s.tm.rise; // R23

  // tracking setpoint: scaled reference capped by mode limit
  always_comb
  begin
    if (s.rp.trk == cfs_pkg::T_RA_OUT || s.rp.trk == cfs_pkg::T_RA_REF)
      scaled = 16'((32'(tracking_reference_in) * 32'(s.pct))
               / cfs_pkg::PCT_FULL); // R20
    else
      scaled = tracking_reference_in; // R18 R19
    case (s.rp.trk)
      cfs_pkg::T_CO_OUT: trk_lim = s.tgt; // R18
      cfs_pkg::T_RA_OUT: trk_lim = 16'((32'(s.tgt) * 32'(s.pct))
                                   / cfs_pkg::PCT_FULL); // R21
      cfs_pkg::T_RA_REF: trk_lim = s.tgt; // R22
      default: trk_lim = 16'hffff; // R19
    endcase
    trk_ref = (scaled < trk_lim) ? scaled : trk_lim;
  end

  // linear ramp from the sampled level, landing on target at the end
  always_comb
  begin
    if (s.above || s.tm.rise == 8'h00)
      ramp_ref = s.sv; // R9
    else
      ramp_ref = s.sv + 16'((32'(s.tgt - s.sv) * 32'(s.ms))
                 / 32'(s.tm.rise)); // R8
  end

  // clamp software lockout writes into the legal window
  always_comb
  begin
    if (hwdata[15:0] < cfs_pkg::LOCK_MIN)
      wlock = cfs_pkg::LOCK_MIN; // R2
    else if (hwdata[15:0] > cfs_pkg::LOCK_MAX)
      wlock = cfs_pkg::LOCK_MAX; // R2
    else
      wlock = hwdata[15:0]; // R2
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic hit, restart, live, clr;
    cfs_pkg::fault_t f;
    cfs_pkg::resp_t r;
    hit = 1'b0;
    restart = 1'b0;
    live = 1'b0;
    clr = 1'b0;
    f = cfs_pkg::F_UV;
    r = cfs_pkg::R_CONT;
    n = s;
    // straps are caught once, on the first edge after reset release
    if (!s.sdone)
    begin
      n.sdone = 1'b1;
      n.lock = strap_high_lockout ? cfs_pkg::LOCK_HI : cfs_pkg::LOCK_LO; // R1
      n.pct = ratio_strap; // R20
    end
    // bus slave: zero wait states, read data captured at address phase
    n.rdy = 1'b1;
    n.wr = hsel && htrans[1] && hready && hwrite;
    n.wa = haddr[4:0];
    if (hsel && htrans[1] && hready && !hwrite)
      n.rdata = rd(s, haddr[4:0], {uv_now, ov_now, overcurrent_in, ot_now});
    if (s.wr)
    begin
      if (s.wa == cfs_pkg::A_CTRL)
      begin
        n.en = hwdata[cfs_pkg::CTRL_EN];
        restart = hwdata[cfs_pkg::CTRL_RESTART];
      end
      else if (s.wa == cfs_pkg::A_LOCK)
        n.lock = wlock; // R2
      else if (s.wa == cfs_pkg::A_TGT)
        n.tgt = hwdata[15:0];
      else if (s.wa == cfs_pkg::A_TIME)
        n.tm = hwdata;
      else if (s.wa == cfs_pkg::A_RESP)
        n.rp = hwdata;
      else if (s.wa == cfs_pkg::A_TEMP)
        n.tlim = hwdata[7:0]; // R14
    end
    // millisecond base, restarted whenever a timed phase begins
    n.tcnt = tick ? 16'h0000 : s.tcnt + 16'h0001;
    if (tick && s.ms != 8'hff)
      n.ms = s.ms + 8'h01;
    case (s.flt)
      cfs_pkg::F_UV: clr = !uv_now;
      cfs_pkg::F_OV: clr = !ov_now;
      cfs_pkg::F_OC: clr = !overcurrent_in;
      default: clr = cool; // R16
    endcase
    case (s.st)
      cfs_pkg::S_OFF:
        if (s.en && !uv_now)
        begin
          n.st = cfs_pkg::S_DELAY;
          n.ms = 8'h00;
          n.tcnt = 16'h0000;
        end
      cfs_pkg::S_DELAY:
        if (s.ms >= s.tm.on_dly)
        begin
          n.st = cfs_pkg::S_RAMP; // R8 R9
          n.sv = output_sense_in;
          n.above = output_sense_in > s.tgt;
          n.ref_mv = trk_on ? trk_ref : output_sense_in;
          n.hs = 1'b1;
          n.ls = 1'b1;
          n.ms = 8'h00;
          n.tcnt = 16'h0000;
        end
      cfs_pkg::S_RAMP:
        if (s.ms >= rise_eff)
        begin
          n.st = cfs_pkg::S_RUN;
          n.ref_mv = trk_on ? trk_ref : s.tgt; // R8 R9
          n.good = 1'b1; // R10
          n.att = 4'h0; // R24
        end
        else
          n.ref_mv = trk_on ? trk_ref : ramp_ref; // R8
      cfs_pkg::S_RUN:
        n.ref_mv = trk_on ? trk_ref : s.tgt; // R19
      cfs_pkg::S_WAIT, cfs_pkg::S_LOWHOLD:
        if (tick && s.ms + 8'h01 >= s.tm.rty_dly)
        begin
          n.ms = 8'h00;
          // a fault still present means wait another full period
          if (clr)
          begin
            n.st = cfs_pkg::S_DELAY; // R16
            n.ls = 1'b0;
          end
        end
      default:
        if (restart)
        begin
          n.st = cfs_pkg::S_OFF;
          n.ls = 1'b0; // R6
          n.att = 4'h0;
        end
    endcase
    // fault arbitration, overvoltage first; ignored faults never hit
    live = s.st == cfs_pkg::S_RAMP || s.st == cfs_pkg::S_RUN;
    if ((live || (s.st == cfs_pkg::S_DELAY && s.ms >= s.tm.on_dly))
        && ov_now)
    begin
      hit = 1'b1; // R11
      f = cfs_pkg::F_OV;
      r = ovr; // R6 R7
    end
    else if (live && overcurrent_in && s.rp.oc != cfs_pkg::R_CONT)
    begin
      hit = 1'b1; // R12 R13
      f = cfs_pkg::F_OC;
      r = s.rp.oc;
    end
    else if (live && ot_now && s.rp.ot != cfs_pkg::R_CONT)
    begin
      hit = 1'b1; // R14 R15 R17
      f = cfs_pkg::F_OT;
      r = s.rp.ot;
    end
    else if (live && uv_now && uvr != cfs_pkg::R_CONT)
    begin
      hit = 1'b1; // R3 R4
      f = cfs_pkg::F_UV;
      r = uvr;
    end
    if (hit)
    begin
      n.good = 1'b0; // R5
      n.flt = f;
    end
    if (!hit || r != cfs_pkg::R_DLY)
      n.dcnt = 8'h00;
    if (hit)
    begin
      case (r)
        cfs_pkg::R_DLY:
        begin
          n.good = s.good;
          if (tick)
            n.dcnt = s.dcnt + 8'h01;
          if (s.dcnt >= s.tm.flt_dly)
            n.st = cfs_pkg::S_LATCH; // R3
        end
        cfs_pkg::R_INF:
          n.st = cfs_pkg::S_WAIT; // R12
        default:
          if (s.att < s.rp.rty_max)
          begin
            n.att = s.att + 4'h1; // R3 R12
            n.st = (r == cfs_pkg::R_LOW) ? cfs_pkg::S_LOWHOLD :
                   cfs_pkg::S_WAIT; // R6
          end
          else
            n.st = cfs_pkg::S_LATCH; // R4 R13 R17
      endcase
      if (n.st != s.st)
      begin
        n.hs = 1'b0;
        // low side stays on, latched or not, until a restart is tried
        n.ls = r == cfs_pkg::R_LOW; // R6
        n.ms = 8'h00;
        n.tcnt = 16'h0000;
        n.good = 1'b0;
      end
    end
    // disabling overrides everything and drops the stage at once
    if (!n.en)
    begin
      n.st = cfs_pkg::S_OFF;
      n.hs = 1'b0;
      n.ls = 1'b0;
      n.good = 1'b0;
      n.att = 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= cfs_pkg::ST_RST;
    else
      s <= n;
  end

  assign hreadyout = s.rdy;
  assign hresp = 1'b0 & s.rdy;
  assign hrdata = s.rdata;
  assign power_good_out = s.good;
  assign high_side_en = s.hs;
  assign low_side_en = s.ls;
  assign ref_mv = s.ref_mv;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_strap;
    $rose(s.sdone) |-> s.lock == ($past(strap_high_lockout) ?
      cfs_pkg::LOCK_HI : cfs_pkg::LOCK_LO);
  endproperty
  a_strap: assert property (p_strap) // R1
    else $error("lockout strap not applied");

  property p_lock_win;
    s.wr && s.wa == cfs_pkg::A_LOCK |=> s.lock >= cfs_pkg::LOCK_MIN
      && s.lock <= cfs_pkg::LOCK_MAX;
  endproperty
  a_lock_win: assert property (p_lock_win) // R2
    else $error("lockout threshold outside window");

  property p_ov_good;
    s.st == cfs_pkg::S_RUN && ov_now && n.en |=> !s.good && !s.hs;
  endproperty
  a_ov_good: assert property (p_ov_good) // R5
    else $error("power good kept through overvoltage");

  property p_ext_ov;
    ext_clock_in |-> ##1 s.st != cfs_pkg::S_LOWHOLD || $past(s.st)
      == cfs_pkg::S_LOWHOLD;
  endproperty
  a_ext_ov: assert property (p_ext_ov) // R7
    else $error("low-side hold entered on external clock");

  property p_good_end;
    $rose(s.good) |-> $past(s.st) == cfs_pkg::S_RAMP
      && $past(s.ms) >= $past(rise_eff) && !$past(ov_now);
  endproperty
  a_good_end: assert property (p_good_end) // R10
    else $error("power good outside ramp end");

  property p_ramp_land;
    s.st == cfs_pkg::S_RAMP && !trk_on && s.ms >= rise_eff && n.en
      && n.st == cfs_pkg::S_RUN |=> s.ref_mv == $past(s.tgt);
  endproperty
  a_ramp_land: assert property (p_ramp_land) // R8
    else $error("ramp did not land on target");

  property p_prebias_ov;
    s.st == cfs_pkg::S_DELAY && s.ms >= s.tm.on_dly && ov_now
      |=> !s.hs ##0 s.flt == cfs_pkg::F_OV;
  endproperty
  a_prebias_ov: assert property (p_prebias_ov) // R11
    else $error("start taken above overvoltage limit");

  property p_hot_restart;
    $past(s.st) == cfs_pkg::S_WAIT && s.st == cfs_pkg::S_DELAY
      && s.flt == cfs_pkg::F_OT |-> $past(cool);
  endproperty
  a_hot_restart: assert property (p_hot_restart) // R16
    else $error("thermal restart while still hot");

  property p_att_clr;
    s.st == cfs_pkg::S_RUN && $past(s.st) == cfs_pkg::S_RAMP
      |-> s.att == 4'h0;
  endproperty
  a_att_clr: assert property (p_att_clr) // R24
    else $error("retry counter kept after restart");

  property p_trk_min;
    s.st == cfs_pkg::S_RUN && $past(s.st) == cfs_pkg::S_RAMP && trk_on
      |-> $past(s.ms) >= cfs_pkg::TRK_MIN_MS;
  endproperty
  a_trk_min: assert property (p_trk_min) // R23
    else $error("tracked ramp shorter than floor");

  c_good: cover property ($rose(s.good));
  c_lowhold: cover property (s.st == cfs_pkg::S_LOWHOLD);
  c_retry: cover property ($past(s.st) == cfs_pkg::S_WAIT
    && s.st == cfs_pkg::S_DELAY);
  c_latch: cover property (s.st == cfs_pkg::S_LATCH);
endmodule : converter_fault_supervisor
`default_nettype wire

// *** verif/power_stage_model.sv ***
`default_nettype none
// ----------------------------------------------------------------
// power stage and output sense stand-in
// ----------------------------------------------------------------
module power_stage_model (
  input wire logic hclk,
  input wire logic high_side_en,
  input wire logic low_side_en,
  input wire logic [15:0] ref_mv,
  input wire logic [15:0] bias_mv,
  input wire logic force_bias,
  output logic [15:0] output_sense_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial output_sense_in = 16'h0000;

  // the node lags the setpoint by one cycle, so a fault never shows in
  // the same cycle as its cause; low side alone grounds the node, and an
  // idle stage leaves the external pre-bias showing
  always @(posedge hclk)
  begin
    if (force_bias)
      output_sense_in <= bias_mv;
    else if (high_side_en)
      output_sense_in <= ref_mv;
    else if (low_side_en)
      output_sense_in <= 16'h0000;
    else
      output_sense_in <= bias_mv;
  end
endmodule : power_stage_model
`default_nettype wire

// *** verif/converter_fault_supervisor_bench.sv ***
`default_nettype none
module converter_fault_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  localparam int MSC = 20; // cycles per ms, short for simulation
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, power_good_out, high_side_en, low_side_en;
  logic [31:0] hrdata, rd;
  logic [15:0] ref_mv, output_sense_in, bias_mv = 16'h0;
  logic [15:0] vin_mv = 16'h2ee0; // 12 V
  logic [15:0] tracking_reference_in = 16'h0514; // 1.3 V
  logic [7:0] die_temp = 8'h19;
  logic overcurrent_in = 1'b0;
  logic ext_clock_in = 1'b0;
  logic strap_high_lockout = 1'b1;
  logic [6:0] ratio_strap = 7'h32;
  logic force_bias = 1'b0;
  int failures = 0;
  int n_checks = 0;
  // fault table: response word, fault kind, expected {pg, hs, ls}
  localparam logic [31:0] resp_tab [11] = '{32'h0f000492, 32'h0f0004a2,
    32'h0f0004a2, 32'h0f000492, 32'h0f000412, 32'h0f000452, 32'h0f000492,
    32'h0f000092, 32'h0f000492, 32'h0f000490, 32'h0f0004d2};
  localparam logic [1:0] kind_tab [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1,
    2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
  localparam logic [2:0] exp_tab [11] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h7,
    3'h7, 3'h0, 3'h7, 3'h0, 3'h7, 3'h0};
  // ratio entries follow the 40 % strap left by the second reset
  localparam logic [15:0] trk_exp [4] = '{16'h04b0, 16'h0514, 16'h01e0,
    16'h0208};

  // free-running bus clock
  always #25 hclk = ~hclk;

  converter_fault_supervisor #(.MS_CYCLES(MSC)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .vin_mv(vin_mv), .output_sense_in(output_sense_in),
    .tracking_reference_in(tracking_reference_in), .die_temp(die_temp),
    .overcurrent_in(overcurrent_in), .ext_clock_in(ext_clock_in),
    .strap_high_lockout(strap_high_lockout), .ratio_strap(ratio_strap),
    .power_good_out(power_good_out), .high_side_en(high_side_en),
    .low_side_en(low_side_en), .ref_mv(ref_mv));

  power_stage_model u_stage (.hclk(hclk), .high_side_en(high_side_en),
    .low_side_en(low_side_en), .ref_mv(ref_mv), .bias_mv(bias_mv),
    .force_bias(force_bias), .output_sense_in(output_sense_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // polls hready or a supervisor output; a hang ends the run
  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while ((sel == 0 ? hreadyout : sel == 1 ? high_side_en :
            power_good_out) !== 1'b1 && n < lim);
    if (n >= lim)
    begin
      failures++;
      $display("mismatch at %0t: wait ran out", $time);
      complete_run();
    end
  endtask : wait_for

  // one AHB single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_for(0, 64, n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_for(0, 64, n);
    rd = hrdata;
  endtask : bus

  task automatic wait_ms(input int n);
    repeat (n * MSC) @(posedge hclk);
  endtask : wait_ms

  // disable clears any latch, then a fresh enable with the given bias
  task automatic start_run(input logic [15:0] b);
    bus(1'b1, cfs_pkg::A_CTRL, 32'h0);
    bias_mv <= b;
    bus(1'b1, cfs_pkg::A_CTRL, 32'h1);
  endtask : start_run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_case(input logic s);
    hresetn <= 1'b0;
    strap_high_lockout <= s;
    ratio_strap <= s ? 7'h32 : 7'h28; // 50 % or 40 %
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, cfs_pkg::A_LOCK, 32'h0);
    chk(rd, s ? cfs_pkg::LOCK_HI : cfs_pkg::LOCK_LO, "strap lockout");
    $display("reset with strap %0b done", s);
  endtask : reset_case

  task automatic reg_case();
    logic [15:0] wr_tab [3] = '{16'h0100, 16'h5000, 16'h0dac};
    logic [15:0] rd_tab [3] = '{16'h0b22, 16'h3e80, 16'h0dac};
    bus(1'b0, cfs_pkg::A_RESP, 32'h0);
    chk(rd, cfs_pkg::RESP_RST, "response defaults");
    bus(1'b0, cfs_pkg::A_TEMP, 32'h0);
    chk(rd, 32'h7d, "thermal limit default");
    bus(1'b0, cfs_pkg::A_TIME, 32'h0);
    chk(rd, cfs_pkg::TIME_RST, "timing defaults");
    bus(1'b0, 5'h1c, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(hresp, 1'b0, "okay response");
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, cfs_pkg::A_LOCK, {16'h0, wr_tab[i]});
      bus(1'b0, cfs_pkg::A_LOCK, 32'h0);
      chk(rd, {16'h0, rd_tab[i]}, "lockout clamp");
    end
    bus(1'b1, cfs_pkg::A_LOCK, {16'h0, cfs_pkg::LOCK_LO});
    $display("register test done");
  endtask : reg_case

  // pre-bias zero, below target and above target (under the OV limit)
  task automatic ramp_case(input logic [15:0] b);
    int n;
    start_run(b);
    wait_for(1, 400, n);
    chk(n >= 95 && n <= 106, 1'b1, "turn-on delay");
    chk({high_side_en, low_side_en, ref_mv}, {2'h3, b}, "ramp start");
    wait_for(2, 400, n);
    chk(n >= 95 && n <= 106, 1'b1, "ramp length");
    chk(ref_mv, cfs_pkg::TGT_RST, "final setpoint");
    $display("ramp from %h done", b);
  endtask : ramp_case

  task automatic fault_case(input int i);
    int n;
    bus(1'b1, cfs_pkg::A_RESP, resp_tab[i]);
    ext_clock_in <= (i == 2);
    start_run(16'h0);
    wait_for(2, 500, n);
    force_bias <= (kind_tab[i] == 2'h0);
    bias_mv <= 16'h0578; // 1.4 V, above target plus 15 %
    overcurrent_in <= (kind_tab[i] == 2'h1);
    die_temp <= (kind_tab[i] == 2'h2) ? 8'h82 : 8'h19;
    vin_mv <= (kind_tab[i] == 2'h3) ? 16'h0fa0 : 16'h2ee0;
    repeat (3) @(posedge hclk);
    chk({power_good_out, high_side_en, low_side_en}, exp_tab[i],
        "fault response");
    force_bias <= 1'b0;
    overcurrent_in <= 1'b0;
    die_temp <= 8'h19;
    vin_mv <= 16'h2ee0;
    ext_clock_in <= 1'b0;
    $display("fault entry %0d done", i);
  endtask : fault_case

  // a trip with retries allowed waits for the full margin below the limit
  task automatic thermal_case();
    int n;
    bus(1'b1, cfs_pkg::A_RESP, 32'h0f003492);
    start_run(16'h0);
    wait_for(2, 500, n);
    die_temp <= 8'h82;
    repeat (3) @(posedge hclk);
    die_temp <= 8'h73; // under the limit, not by the margin
    bus(1'b0, cfs_pkg::A_STAT, 32'h0);
    chk({rd[12:10], rd[7:4]}, {3'h4, 4'h1}, "waiting to retry");
    wait_ms(20);
    chk(high_side_en, 1'b0, "restart held while hot");
    die_temp <= 8'h6e;
    wait_for(2, 900, n);
    bus(1'b0, cfs_pkg::A_STAT, 32'h0);
    chk(rd[7:4], 4'h0, "attempts after restart");
    $display("thermal retry test done");
  endtask : thermal_case

  task automatic no_start_case();
    int n;
    bus(1'b1, cfs_pkg::A_RESP, cfs_pkg::RESP_RST);
    vin_mv <= 16'h0fa0;
    start_run(16'h0);
    wait_ms(12);
    chk(high_side_en, 1'b0, "start under lockout");
    vin_mv <= 16'h2ee0;
    start_run(16'h05dc); // pre-bias above the OV limit
    wait_ms(12);
    bus(1'b0, cfs_pkg::A_STAT, 32'h0);
    chk({power_good_out, high_side_en, rd[9:8]}, 4'h1, "OV pre-bias");
    // the restart bit, written with enable still set, must bring a latched stage back up
    bias_mv <= 16'h0000;
    bus(1'b1, cfs_pkg::A_CTRL, 32'h3);
    wait_for(2, 500, n);
    chk(ref_mv, cfs_pkg::TGT_RST, "restart from latch");
    $display("blocked start test done");
  endtask : no_start_case

  // rise stays at its 5 ms default, the floor for tracked ramps
  task automatic track_case();
    for (int k = 1; k < 5; k++)
    begin
      bus(1'b1, cfs_pkg::A_RESP, cfs_pkg::RESP_RST | {13'h0, k[2:0], 16'h0});
      start_run(16'h0);
      wait_ms(12);
      chk(ref_mv, trk_exp[k-1], "tracked level");
    end
    $display("tracking test done");
  endtask : track_case

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_case(1'b1);
    reset_case(1'b0);
    reg_case();
    ramp_case(16'h0);
    ramp_case(16'h0258);
    ramp_case(16'h0514);
    for (int i = 0; i < 11; i++)
      fault_case(i);
    thermal_case();
    no_start_case();
    track_case();
    complete_run();
  end
endmodule : converter_fault_supervisor_bench
`default_nettype wire
